// [common/pmtx_fifo_if.sv]
// Handshake bundle between the link logic and its transmit FIFO
`timescale 1ns/10ps
`default_nettype none
interface pmtx_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;
  logic flush;

  modport ctrl (output wdata, wvalid, rready, flush,
                input wready, rdata, rvalid);
  modport store (input wdata, wvalid, rready, flush,
                 output wready, rdata, rvalid);
endinterface
`default_nettype wire

// [common/pmtx_pkg.sv]
// Constants and types shared by the link control register block
package pmtx_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int NUM_EDGE_ALARMS = 8;
  localparam int NUM_RISE_ALARMS = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_TX_FIFO = 6'h37;
  localparam logic [ADDR_W-1:0] ADDR_LINK_CTRL = 6'h3d;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HIGH = 6'h3e;
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 6'h3f;

  // Link control field positions
  localparam int BIT_DEJITTER = 7;
  localparam int BIT_IRQ_POL = 6;
  localparam int BIT_RX_HALF_IE = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_END_OF_MSG = 2;
  localparam int BIT_TX_HALF_IE = 1;
  localparam int BIT_TX_LINK_EN = 0;

  // Edge select field positions
  localparam int BIT_RISE = 1;
  localparam int BIT_FALL = 0;

  // Reset values and writable masks; masked bits read as zero
  localparam logic [DATA_W-1:0] LINK_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] LINK_CTRL_WMASK = 8'hf7;
  localparam logic [DATA_W-1:0] CNT_HIGH_RST = 8'h00;
  localparam logic [DATA_W-1:0] EDGE_SEL_RST = 8'h00;
  localparam logic [DATA_W-1:0] EDGE_SEL_WMASK = 8'h03;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

  // HDLC framing
  localparam logic [15:0] HDLC_FLAG = 16'h007e;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] FCS_LAST = 4'hf;

  typedef enum logic [1:0] {
    TX_FLAG = 2'b00,
    TX_DATA = 2'b01,
    TX_FCS = 2'b11
  } pmtx_tx_state_t;
endpackage

// [rtl/pmtx_edge_irq.sv]
// Per-alarm transition detector producing interrupt request set pulses
`timescale 1ns/10ps
`default_nettype none
module pmtx_edge_irq #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] alarm,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic [N-1:0] set_q
);
  logic [N-1:0] prev_q;
  logic [N-1:0] set_d;

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_comb begin
      set_d[i] = (rise_en && alarm[i] && !prev_q[i]) ||
                 (fall_en && !alarm[i] && prev_q[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
      set_q <= '0;
    end else begin
      prev_q <= alarm;
      set_q <= set_d;
    end
  end
endmodule
`default_nettype wire

// [rtl/pmtx_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and a flush input
`timescale 1ns/10ps
`default_nettype none
module pmtx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  pmtx_fifo_if.store f
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic push, pop;

  assign f.wready = (count_q != FULL_CNT);
  assign f.rvalid = (count_q != '0);
  assign f.rdata = mem_q[rd_ptr_q];
  assign push = f.wvalid && f.wready && !f.flush;
  assign pop = f.rready && f.rvalid && !f.flush;

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    if (f.flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end else begin
      if (push) begin
        wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_d = count_q + 1'b1;
      end else if (pop && !push) begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // Data storage needs no reset; count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= f.wdata;
    end
  end
endmodule
`default_nettype wire

// [rtl/pmtx_link_regs.sv]
// Transmit link control, counter high-byte latch and alarm edge select
`timescale 1ns/10ps
`default_nettype none
module pmtx_link_regs
  import pmtx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [DATA_W-1:0] cpu_wdata,
  output logic [DATA_W-1:0] cpu_rdata_q,
  input wire logic cnt_low_rd,
  input wire logic [DATA_W-1:0] cnt_high_byte,
  output logic tx_fifo_ready_q,
  input wire logic cbit_slot,
  input wire logic ext_cbit,
  input wire logic stuff_cbit,
  input wire logic legacy_format_select,
  output logic path_maintenance_link_q,
  output logic [DATA_W-1:0] link_ctrl_q,
  output logic tx_msg_done_q,
  output logic tx_underflow_q,
  input wire logic [NUM_EDGE_ALARMS-1:0] alarm_edge,
  input wire logic [NUM_RISE_ALARMS-1:0] alarm_rise,
  output logic [NUM_EDGE_ALARMS-1:0] edge_irq_set_q,
  output logic [NUM_RISE_ALARMS-1:0] rise_irq_set_q
);
  pmtx_fifo_if #(.WIDTH(DATA_W)) fifo ();

  logic [DATA_W-1:0] link_ctrl_d;
  logic [DATA_W-1:0] cnt_high_q, cnt_high_d;
  logic [DATA_W-1:0] edge_sel_q, edge_sel_d;
  logic [DATA_W-1:0] cpu_rdata_d;
  logic tx_fifo_ready_d;
  logic ext_meta_q, ext_sync_q;

  pmtx_tx_state_t st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [2:0] ones_q, ones_d;
  logic [15:0] crc_q, crc_d;
  logic path_maintenance_link_d;
  logic tx_msg_done_d, tx_underflow_d;
  logic eom_clr;
  logic tx_en;
  logic wr_ctrl, wr_fifo;

  // Reflected CRC-16 step, one bit, least significant first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = (c >> 1) ^ (fb ? CRC_POLY_REV : 16'h0000);
  endfunction

  assign tx_en = link_ctrl_q[BIT_TX_LINK_EN];
  assign wr_ctrl = cpu_wr && (cpu_addr == ADDR_LINK_CTRL);
  assign wr_fifo = cpu_wr && (cpu_addr == ADDR_TX_FIFO);

  // Bytes enter only while the transmitter runs; full drops the write
  assign fifo.wdata = cpu_wdata;
  assign fifo.wvalid = wr_fifo && tx_en;
  assign fifo.flush = !tx_en;

  pmtx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .f(fifo.store)
  );

  // General alarm requests follow the edge select bits
  pmtx_edge_irq #(
    .N(NUM_EDGE_ALARMS)
  ) u_edge_sel (
    .clk(clk),
    .rst(rst),
    .alarm(alarm_edge),
    .rise_en(edge_sel_q[BIT_RISE]),
    .fall_en(edge_sel_q[BIT_FALL]),
    .set_q(edge_irq_set_q)
  );

  // Dedicated requests are fixed to entry, whatever the selects say
  pmtx_edge_irq #(
    .N(NUM_RISE_ALARMS)
  ) u_edge_rise (
    .clk(clk),
    .rst(rst),
    .alarm(alarm_rise),
    .rise_en(1'b1),
    .fall_en(1'b0),
    .set_q(rise_irq_set_q)
  );

  // Register writes, latch and read mux
  always_comb begin
    link_ctrl_d = link_ctrl_q;
    if (wr_ctrl) begin
      link_ctrl_d = cpu_wdata & LINK_CTRL_WMASK;
    end
    // A software set arriving with the hardware clear wins
    if (eom_clr && !(wr_ctrl && cpu_wdata[BIT_END_OF_MSG])) begin
      link_ctrl_d[BIT_END_OF_MSG] = 1'b0;
    end

    edge_sel_d = edge_sel_q;
    if (cpu_wr && (cpu_addr == ADDR_EDGE_SEL)) begin
      // Upper bits are not stored, so stray ones read back as zero
      edge_sel_d = cpu_wdata & EDGE_SEL_WMASK;
    end

    cnt_high_d = cnt_high_q;
    if (cnt_low_rd) begin
      cnt_high_d = cnt_high_byte;
    end

    cpu_rdata_d = READ_IDLE;
    if (cpu_rd) begin
      unique case (cpu_addr)
        ADDR_LINK_CTRL: cpu_rdata_d = link_ctrl_q;
        ADDR_CNT_HIGH: cpu_rdata_d = cnt_high_q;
        ADDR_EDGE_SEL: cpu_rdata_d = edge_sel_q;
        default: cpu_rdata_d = READ_IDLE;
      endcase
    end

    tx_fifo_ready_d = fifo.wready && tx_en;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link_ctrl_q <= LINK_CTRL_RST;
      edge_sel_q <= EDGE_SEL_RST;
      cnt_high_q <= CNT_HIGH_RST;
      cpu_rdata_q <= READ_IDLE;
      tx_fifo_ready_q <= 1'b0;
    end else begin
      link_ctrl_q <= link_ctrl_d;
      edge_sel_q <= edge_sel_d;
      cnt_high_q <= cnt_high_d;
      cpu_rdata_q <= cpu_rdata_d;
      tx_fifo_ready_q <= tx_fifo_ready_d;
    end
  end

  // External C-bit arrives from a pin
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_cbit;
      ext_sync_q <= ext_meta_q;
    end
  end

  // HDLC transmitter, one bit per link C-bit slot
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bitcnt_d = bitcnt_q;
    ones_d = ones_q;
    crc_d = crc_q;
    path_maintenance_link_d = path_maintenance_link_q;
    fifo.rready = 1'b0;
    eom_clr = 1'b0;
    tx_msg_done_d = 1'b0;
    tx_underflow_d = 1'b0;
    if (cbit_slot) begin
      if (!tx_en) begin
        // Restart cleanly with a flag when enabled again
        st_d = TX_FLAG;
        sh_d = HDLC_FLAG;
        bitcnt_d = '0;
        ones_d = '0;
        path_maintenance_link_d = legacy_format_select ? stuff_cbit
                                                       : ext_sync_q;
      end else if (ones_q == STUFF_LIMIT) begin
        // Zero insertion; shifter holds its place
        path_maintenance_link_d = 1'b0;
        ones_d = '0;
      end else begin
        path_maintenance_link_d = sh_q[0];
        sh_d = sh_q >> 1;
        bitcnt_d = bitcnt_q + 1'b1;
        unique case (st_q)
          TX_FLAG: begin
            ones_d = '0;
            if (bitcnt_q == BYTE_LAST) begin
              bitcnt_d = '0;
              crc_d = CRC_INIT;
              if (fifo.rvalid) begin
                sh_d = {8'h00, fifo.rdata};
                fifo.rready = 1'b1;
                st_d = TX_DATA;
              end else begin
                sh_d = HDLC_FLAG;
              end
            end
          end
          TX_DATA: begin
            ones_d = sh_q[0] ? ones_q + 1'b1 : '0;
            crc_d = crc_step(crc_q, sh_q[0]);
            if (bitcnt_q == BYTE_LAST) begin
              bitcnt_d = '0;
              if (fifo.rvalid) begin
                sh_d = {8'h00, fifo.rdata};
                fifo.rready = 1'b1;
              end else if (link_ctrl_q[BIT_END_OF_MSG]) begin
                sh_d = ~crc_step(crc_q, sh_q[0]);
                st_d = TX_FCS;
              end else begin
                // Ran dry without an end mark: close with a flag
                sh_d = HDLC_FLAG;
                st_d = TX_FLAG;
                tx_underflow_d = 1'b1;
              end
            end
          end
          TX_FCS: begin
            ones_d = sh_q[0] ? ones_q + 1'b1 : '0;
            if (bitcnt_q == FCS_LAST) begin
              bitcnt_d = '0;
              sh_d = HDLC_FLAG;
              st_d = TX_FLAG;
              eom_clr = 1'b1;
              tx_msg_done_d = 1'b1;
            end
          end
          default: begin
            st_d = TX_FLAG;
            sh_d = HDLC_FLAG;
            bitcnt_d = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= TX_FLAG;
      sh_q <= HDLC_FLAG;
      bitcnt_q <= '0;
      ones_q <= '0;
      crc_q <= CRC_INIT;
      path_maintenance_link_q <= 1'b0;
      tx_msg_done_q <= 1'b0;
      tx_underflow_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bitcnt_q <= bitcnt_d;
      ones_q <= ones_d;
      crc_q <= crc_d;
      path_maintenance_link_q <= path_maintenance_link_d;
      // Events only reach the interrupt logic while enabled
      tx_msg_done_q <= tx_msg_done_d && tx_en;
      tx_underflow_q <= tx_underflow_d && tx_en;
    end
  end
endmodule
`default_nettype wire

// [testbench/pmtx_far_end.sv]
// Far-end C-bit slot source with stuffing and external bit streams
`timescale 1ns/10ps
`default_nettype none
module pmtx_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_level,
  output logic cbit_slot,
  output var logic stuff_cbit,
  output logic ext_cbit
);
  logic [1:0] div_q;
  // Sparse slots, so the serialiser idles between bits
  always @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
      stuff_cbit <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        stuff_cbit <= ~stuff_cbit;
      end
    end
  end
  assign cbit_slot = div_q == 2'h3;
  assign ext_cbit = ext_level;
endmodule
`default_nettype wire

// [testbench/pmtx_link_asserts.sv]
// Port-level checks for the link control register block
`timescale 1ns/10ps
`default_nettype none
module pmtx_link_asserts
  import pmtx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [DATA_W-1:0] cpu_wdata,
  input wire logic [DATA_W-1:0] cpu_rdata_q,
  input wire logic cnt_low_rd,
  input wire logic [DATA_W-1:0] cnt_high_byte,
  input wire logic tx_fifo_ready_q,
  input wire logic cbit_slot,
  input wire logic stuff_cbit,
  input wire logic legacy_format_select,
  input wire logic path_maintenance_link_q,
  input wire logic [DATA_W-1:0] link_ctrl_q,
  input wire logic tx_msg_done_q,
  input wire logic tx_underflow_q,
  input wire logic [NUM_EDGE_ALARMS-1:0] alarm_edge,
  input wire logic [NUM_RISE_ALARMS-1:0] alarm_rise,
  input wire logic [NUM_EDGE_ALARMS-1:0] edge_irq_set_q,
  input wire logic [NUM_RISE_ALARMS-1:0] rise_irq_set_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] sel_q;
  logic [15:0] p1_q;
  logic [15:0] p2_q;
  // History resets to zero, as the detector's own history does
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 2'h0;
      p1_q <= 16'h0000;
      p2_q <= 16'h0000;
    end else begin
      if (cpu_wr && cpu_addr == ADDR_EDGE_SEL) begin
        sel_q <= cpu_wdata[1:0];
      end
      p1_q <= {alarm_rise, alarm_edge};
      p2_q <= p1_q;
    end
  end
  wire logic [7:0] er = p1_q[7:0] & ~p2_q[7:0];
  wire logic [7:0] ef = ~p1_q[7:0] & p2_q[7:0];
  sequence s_hi_rd;
    cpu_rd && cpu_addr == ADDR_CNT_HIGH && !cnt_low_rd;
  endsequence
  none_sel_a:
    assert property ($past(sel_q) == 2'h0 |-> edge_irq_set_q == 8'h00)
    else $error("edge request with both selects off");
  fall_only_a:
    assert property ($past(sel_q) == 2'h1 |-> edge_irq_set_q == ef)
    else $error("fall-only request mismatch");
  rise_only_a:
    assert property ($past(sel_q) == 2'h2 |-> edge_irq_set_q == er)
    else $error("rise-only request mismatch");
  both_sel_a:
    assert property ($past(sel_q) == 2'h3 |-> edge_irq_set_q == (er | ef))
    else $error("both-edge request mismatch");
  rise_fixed_a:
    assert property (rise_irq_set_q == (p1_q[15:8] & ~p2_q[15:8]))
    else $error("dedicated rise request mismatch");
  hi_latch_a:
    assert property (cnt_low_rd ##1 s_hi_rd |=>
      cpu_rdata_q == $past(cnt_high_byte, 2))
    else $error("high byte not latched");
  hi_hold_a:
    assert property (cnt_low_rd ##1 !cnt_low_rd ##1 !cnt_low_rd ##1 s_hi_rd
      |=> cpu_rdata_q == $past(cnt_high_byte, 4))
    else $error("high byte not held");
  stuff_src_a:
    assert property (cbit_slot && legacy_format_select &&
      !link_ctrl_q[BIT_TX_LINK_EN] |=>
      path_maintenance_link_q == $past(stuff_cbit))
    else $error("disabled link not from stuffing");
  off_quiet_a:
    assert property (!link_ctrl_q[BIT_TX_LINK_EN] &&
      !$past(link_ctrl_q[BIT_TX_LINK_EN]) |->
      !tx_fifo_ready_q && !tx_msg_done_q && !tx_underflow_q)
    else $error("disabled link still active");
endmodule
bind pmtx_link_regs pmtx_link_asserts u_chk (.*);
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the link control register block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pmtx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] cpu_addr = 6'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata_q;
  logic cnt_low_rd = 1'b0;
  logic [7:0] cnt_high_byte = 8'h00;
  logic tx_fifo_ready_q;
  logic cbit_slot;
  logic ext_cbit;
  logic stuff_cbit;
  logic ext_level = 1'b1;
  logic legacy_format_select = 1'b0;
  logic path_maintenance_link_q;
  logic [7:0] link_ctrl_q;
  logic tx_msg_done_q;
  logic tx_underflow_q;
  logic [7:0] alarm_edge = 8'h00;
  logic [7:0] alarm_rise = 8'h00;
  logic [7:0] edge_irq_set_q;
  logic [7:0] rise_irq_set_q;
  logic slot_d = 1'b0;
  logic [15:0] sh = 16'h0000;
  int error_cnt = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  pmtx_far_end far (.clk(clk), .rst(rst), .ext_level(ext_level),
    .cbit_slot(cbit_slot), .stuff_cbit(stuff_cbit), .ext_cbit(ext_cbit));
  pmtx_link_regs DUT (.clk(clk), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata_q(cpu_rdata_q), .cnt_low_rd(cnt_low_rd),
    .cnt_high_byte(cnt_high_byte), .tx_fifo_ready_q(tx_fifo_ready_q),
    .cbit_slot(cbit_slot), .ext_cbit(ext_cbit), .stuff_cbit(stuff_cbit),
    .legacy_format_select(legacy_format_select),
    .path_maintenance_link_q(path_maintenance_link_q),
    .link_ctrl_q(link_ctrl_q),
    .tx_msg_done_q(tx_msg_done_q), .tx_underflow_q(tx_underflow_q),
    .alarm_edge(alarm_edge), .alarm_rise(alarm_rise),
    .edge_irq_set_q(edge_irq_set_q), .rise_irq_set_q(rise_irq_set_q));
  // Line bits arrive least significant first
  always @(posedge clk) begin
    slot_d <= cbit_slot;
    if (slot_d) begin
      sh <= {path_maintenance_link_q, sh[15:1]};
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    step(1);
    cpu_wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    cpu_addr = a;
    cpu_rd = 1'b1;
    step(1);
    cpu_rd = 1'b0;
    check(cpu_rdata_q, exp, "read data");
    step(1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_regs();
    rd(ADDR_LINK_CTRL, LINK_CTRL_RST);
    rd(ADDR_CNT_HIGH, CNT_HIGH_RST);
    rd(ADDR_EDGE_SEL, EDGE_SEL_RST);
    wr(ADDR_EDGE_SEL, 8'h02);
    rd(ADDR_EDGE_SEL, 8'h02);
    wr(6'h10, 8'haa);
    rd(6'h10, READ_IDLE);
    rd(ADDR_TX_FIFO, READ_IDLE);
    $display("test regs done");
  endtask
  task automatic t_latch();
    cnt_high_byte = 8'h5a;
    cnt_low_rd = 1'b1;
    step(1);
    cnt_low_rd = 1'b0;
    cnt_high_byte = 8'ha5;
    rd(ADDR_CNT_HIGH, 8'h5a);
    rd(ADDR_CNT_HIGH, 8'h5a);
    $display("test latch done");
  endtask
  task automatic watch(output logic [7:0] e, output logic [7:0] r);
    e = 8'h00;
    r = 8'h00;
    repeat (6) begin
      step(1);
      e = e | edge_irq_set_q;
      r = r | rise_irq_set_q;
    end
  endtask
  task automatic t_edges();
    logic [7:0] e;
    logic [7:0] r;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_EDGE_SEL, 8'(s));
      step(2);
      alarm_edge = 8'h81;
      alarm_rise = 8'h0f;
      watch(e, r);
      check(e, s[1] ? 8'h81 : 8'h00, "entry");
      check(r, 8'h0f, "dedicated entry");
      alarm_edge = 8'h00;
      alarm_rise = 8'h00;
      watch(e, r);
      check(e, s[0] ? 8'h81 : 8'h00, "removal");
      check(r, 8'h00, "dedicated removal");
    end
    $display("test edges done");
  endtask
  task automatic t_link();
    int n;
    step(20);
    check({7'h00, path_maintenance_link_q}, 8'h01, "ext high");
    ext_level = 1'b0;
    step(20);
    check({7'h00, path_maintenance_link_q}, 8'h00, "ext low");
    legacy_format_select = 1'b1;
    step(12);
    wr(ADDR_LINK_CTRL, 8'h01);
    step(100);
    check(sh[15:8], sh[7:0], "flag period");
    check(8'($countones(sh[7:0])), 8'h06, "flag ones");
    check({7'h00, tx_fifo_ready_q}, 8'h01, "ready");
    wr(ADDR_TX_FIFO, 8'h3c);
    wr(ADDR_LINK_CTRL, 8'h05);
    n = 0;
    while (tx_msg_done_q !== 1'b1) begin
      n++;
      if (n > 600) begin
        check(8'h00, 8'h01, "done timeout");
        report_and_stop();
      end
      step(1);
    end
    step(2);
    rd(ADDR_LINK_CTRL, 8'h01);
    wr(ADDR_LINK_CTRL, 8'h00);
    check({7'h00, tx_fifo_ready_q}, 8'h00, "ready off");
    step(40);
    $display("test link done");
  endtask
  initial begin
    step(5);
    rst = 1'b0;
    step(1);
    t_regs();
    t_latch();
    t_edges();
    t_link();
    report_and_stop();
  end
endmodule
`default_nettype wire
